//--- peripheral_enable_clock_gate.sv
// peripheral function-enable and clock-gate unit with avalon-mm slave.
// assumes one 25 MHz system clock; gated clocks leave through a latch gate.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module peripheral_enable_clock_gate (
  input  wire logic        i_clk,           // system clock
  input  wire logic        i_rst_b,         // sync reset, active low
  input  wire logic [31:0] i_avs_address,   // byte address
  input  wire logic        i_avs_read,      // read request
  input  wire logic        i_avs_write,     // write request
  input  wire logic [31:0] i_avs_writedata, // write data
  input  wire logic [3:0]  i_avs_byteenable,// byte lanes
  output logic      [31:0] o_avs_readdata,  // read data, registered
  output logic             o_avs_waitrequest,// stall
  output logic      [15:0] o_periph_hold,   // peripheral held in reset
  output logic      [15:0] o_periph_clk     // gated peripheral clocks
);

  ////////////////////////////////////////////////////////////////////
  logic [31:0] func_en_1;
  logic [31:0] func_en_2;
  logic [31:0] clk_en_1;
  logic [31:0] clk_en_2;
  logic        ack;
  logic [31:0] next_readdata;
  logic [15:0] func_vec;
  logic [15:0] clk_vec;
  logic [15:0] en_lat;

  wire req       = i_avs_read | i_avs_write;
  wire hit_fe1   = i_avs_address == periph_gate_pkg::ADDR_FUNC_EN_1;
  wire hit_fe2   = i_avs_address == periph_gate_pkg::ADDR_FUNC_EN_2;
  wire hit_ce1   = i_avs_address == periph_gate_pkg::ADDR_CLK_EN_1;
  wire hit_ce2   = i_avs_address == periph_gate_pkg::ADDR_CLK_EN_2;
  // writes land on the edge where waitrequest is low
  wire wr_now    = i_avs_write & ack;
  wire [31:0] be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                         {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  wire [31:0] wfe1 = ((func_en_1 & ~be_mask) | (i_avs_writedata & be_mask))
                     & periph_gate_pkg::MASK_1;
  wire [31:0] wfe2 = ((func_en_2 & ~be_mask) | (i_avs_writedata & be_mask))
                     & periph_gate_pkg::MASK_2;
  wire [31:0] wce1 = ((clk_en_1 & ~be_mask) | (i_avs_writedata & be_mask))
                     & periph_gate_pkg::MASK_1;
  wire [31:0] wce2 = ((clk_en_2 & ~be_mask) | (i_avs_writedata & be_mask))
                     & periph_gate_pkg::MASK_2;

  assign next_readdata = hit_fe1 ? func_en_1 :
                         hit_fe2 ? func_en_2 :
                         hit_ce1 ? clk_en_1  :
                         hit_ce2 ? clk_en_2  : 32'h0000_0000;

  // one wait cycle: answer on the second edge of every request
  assign o_avs_waitrequest = req & ~ack;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ack            <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= req & ~ack;
      if (req & ~ack)
        o_avs_readdata <= next_readdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      func_en_1 <= periph_gate_pkg::RESET_FUNC_EN_1;
      func_en_2 <= periph_gate_pkg::RESET_FUNC_EN_2;
    end else begin
      if (wr_now & hit_fe1)
        func_en_1 <= wfe1;
      if (wr_now & hit_fe2)
        func_en_2 <= wfe2;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      clk_en_1 <= periph_gate_pkg::RESET_CLK_EN_1;
      clk_en_2 <= periph_gate_pkg::RESET_CLK_EN_2;
    end else begin
      if (wr_now & hit_ce1)
        clk_en_1 <= wce1;
      if (wr_now & hit_ce2)
        clk_en_2 <= wce2;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // first-register bit map, index 15 down to 6
  // second-register bit map, index 5 down to 0
  assign func_vec = {
    func_en_1[periph_gate_pkg::BIT_FREE_RUN_TIMER],
    func_en_1[periph_gate_pkg::BIT_TIMER_THREE:periph_gate_pkg::BIT_TIMER_ZERO],
    func_en_1[periph_gate_pkg::BIT_PORT_D:periph_gate_pkg::BIT_PORT_A],
    func_en_1[periph_gate_pkg::BIT_DIVIDER],
    func_en_2[periph_gate_pkg::BIT_ADC],
    func_en_2[periph_gate_pkg::BIT_MOTOR_PWM],
    func_en_2[periph_gate_pkg::BIT_SERIAL_ONE],
    func_en_2[periph_gate_pkg::BIT_SERIAL_ZERO],
    func_en_2[periph_gate_pkg::BIT_I2C],
    func_en_2[periph_gate_pkg::BIT_SPI]};

  assign clk_vec = {
    clk_en_1[periph_gate_pkg::BIT_FREE_RUN_TIMER],
    clk_en_1[periph_gate_pkg::BIT_TIMER_THREE:periph_gate_pkg::BIT_TIMER_ZERO],
    clk_en_1[periph_gate_pkg::BIT_PORT_D:periph_gate_pkg::BIT_PORT_A],
    clk_en_1[periph_gate_pkg::BIT_DIVIDER],
    clk_en_2[periph_gate_pkg::BIT_ADC],
    clk_en_2[periph_gate_pkg::BIT_MOTOR_PWM],
    clk_en_2[periph_gate_pkg::BIT_SERIAL_ONE],
    clk_en_2[periph_gate_pkg::BIT_SERIAL_ZERO],
    clk_en_2[periph_gate_pkg::BIT_I2C],
    clk_en_2[periph_gate_pkg::BIT_SPI]};

  // hold in reset while function bit clear
  assign o_periph_hold = ~func_vec;

  genvar g;
  generate
    for (g = 0; g < periph_gate_pkg::NUM_PERIPH; g++) begin : gate
      // enable only moves while clock is low, so no runt pulse
      always_latch begin
        if (!i_clk)
          en_lat[g] <= clk_vec[g];
      end
      assign o_periph_clk[g] = i_clk & en_lat[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  sequence wr_fe1_s;
    wr_now && hit_fe1;
  endsequence

  sequence wr_ce1_s;
    wr_now && hit_ce1;
  endsequence

  hold_release_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_fe1_s ##0 (wfe1[periph_gate_pkg::BIT_DIVIDER])
      |=> !o_periph_hold[6])
    else $error("divider still held after enable write");

  hold_force_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_fe1_s ##0 (!wfe1[periph_gate_pkg::BIT_FREE_RUN_TIMER])
      |=> o_periph_hold[15])
    else $error("free-run timer not forced into reset");

  reset_default_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !$past(i_rst_b) |-> (o_periph_hold == 14'h0000))
    else $error("peripheral held after system reset");

  clk_start_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_ce1_s ##0 (wce1[periph_gate_pkg::BIT_PORT_A])
      |=> clk_vec[7] ##0 en_lat[7])
    else $error("port a clock did not start");

  clk_stop_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (wr_now && hit_ce2 && !wce2[periph_gate_pkg::BIT_SPI])
      |=> !clk_vec[0] ##0 !en_lat[0])
    else $error("spi clock did not stop");

  gate_follow_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    en_lat == clk_vec)
    else $error("clock gate enable out of step");

  reserved_zero_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_avs_read && !o_avs_waitrequest && (hit_fe2 || hit_ce2))
      |-> (o_avs_readdata & ~periph_gate_pkg::MASK_2) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  answer_time_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (req && o_avs_waitrequest) |=> !o_avs_waitrequest)
    else $error("request not answered in one wait cycle");

  readback_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (wr_now && hit_ce2) |=> (clk_en_2 == $past(wce2)))
    else $error("clock enable 2 did not store write");

  // bus side checks: reserved lanes and unmapped words read back zero
  sequence wr_fe2_s;
    wr_now && hit_fe2;
  endsequence

  sequence wr_ce2_s;
    wr_now && hit_ce2;
  endsequence

  sequence rd_answer_s;
    i_avs_read && !o_avs_waitrequest;
  endsequence

  reserved_low_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_answer_s ##0 (hit_fe1 || hit_ce1)
      |-> (o_avs_readdata & ~periph_gate_pkg::MASK_1) == 32'h0000_0000)
    else $error("reserved bits of first registers read nonzero");

  unmapped_zero_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_answer_s ##0 !(hit_fe1 || hit_fe2 || hit_ce1 || hit_ce2)
      |-> o_avs_readdata == 32'h0000_0000)
    else $error("unmapped address read nonzero");

  // hold side, then clock-enable steady and reset checks: the hold vector moves only on a landed write
  timers_release_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_fe1_s |=> o_periph_hold[14:11] == ~$past(
      wfe1[periph_gate_pkg::BIT_TIMER_THREE:periph_gate_pkg::BIT_TIMER_ZERO]))
    else $error("timer hold does not follow enable write");

  ports_release_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_fe1_s |=> o_periph_hold[10:7] == ~$past(
      wfe1[periph_gate_pkg::BIT_PORT_D:periph_gate_pkg::BIT_PORT_A]))
    else $error("port hold does not follow enable write");

  adc_release_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_fe2_s ##0 wfe2[periph_gate_pkg::BIT_ADC]
      |=> !o_periph_hold[5])
    else $error("adc still held after enable write");

  serial_force_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_fe2_s ##0 !wfe2[periph_gate_pkg::BIT_SERIAL_ONE]
      |=> o_periph_hold[3])
    else $error("serial port one not forced into reset");

  spi_release_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_fe2_s ##0 wfe2[periph_gate_pkg::BIT_SPI] |=> !o_periph_hold[0])
    else $error("spi still held after enable write");

  hold_steady_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !wr_now |=> $stable(o_periph_hold))
    else $error("hold changed without a register write");

  clk_steady_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !wr_now |=> $stable(clk_vec))
    else $error("clock enables changed without a register write");

  clk_reset_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !$past(i_rst_b) |-> clk_vec == 16'h0000)
    else $error("peripheral clock running after system reset");

  // clock side: the latched gate enable follows a landed write
  timer_clk_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_ce1_s ##0 wce1[periph_gate_pkg::BIT_TIMER_ZERO] |=> en_lat[11])
    else $error("timer zero clock did not start");

  free_run_stop_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_ce1_s ##0 !wce1[periph_gate_pkg::BIT_FREE_RUN_TIMER]
      |=> !en_lat[15])
    else $error("free-run timer clock did not stop");

  portd_clk_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_ce1_s ##0 !wce1[periph_gate_pkg::BIT_PORT_D] |=> !en_lat[10])
    else $error("port d clock did not stop");

  serial_clk_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_ce2_s ##0 wce2[periph_gate_pkg::BIT_SERIAL_ZERO]
      |=> clk_vec[2] ##0 en_lat[2])
    else $error("serial port zero clock did not start");

  i2c_clk_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_ce2_s ##0 !wce2[periph_gate_pkg::BIT_I2C] |=> !en_lat[1])
    else $error("i2c clock did not stop");

  pwm_clk_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_ce2_s ##0 wce2[periph_gate_pkg::BIT_MOTOR_PWM] |=> en_lat[4])
    else $error("motor pwm clock did not start");

endmodule // peripheral_enable_clock_gate

//--- periph_gate_pkg.sv
// package for the peripheral function-enable and clock-gate block:
// register byte addresses, implemented-bit masks, reset values, bit map.
// assumes a 32-bit avalon-mm master presenting full byte addresses.
//
// Behaviour
// - function-enable bit one releases peripheral from reset; zero holds it.
// - clearing a function-enable bit forces that peripheral back into reset.
// - after system reset every implemented function-enable bit is one.
// - writing one to a clock-enable bit starts that peripheral's clock.
// - writing zero to a clock-enable bit stops that peripheral's clock.
// - with clock-enable clear the peripheral gets no clock at all.
// - function enable 1 maps free-run, timers, ports and divider bits.
// - function enable 2 maps adc, motor pwm, serial ports, i2c, spi.
// - clock enable 1 gates free-run, timers, ports and divider clocks.
// - clock enable 2 gates adc, motor pwm, serial ports, i2c, spi.
package periph_gate_pkg;
  localparam logic [31:0] ADDR_FUNC_EN_1  = 32'h4000_0028;
  localparam logic [31:0] ADDR_FUNC_EN_2  = 32'h4000_002C;
  localparam logic [31:0] ADDR_CLK_EN_1   = 32'h4000_0030;
  localparam logic [31:0] ADDR_CLK_EN_2   = 32'h4000_0034;
  // implemented bits of the first and second register of each pair
  localparam logic [31:0] MASK_1          = 32'h040F_0F20;
  localparam logic [31:0] MASK_2          = 32'h0011_0311;
  localparam logic [31:0] RESET_FUNC_EN_1 = 32'h040F_0F20;
  localparam logic [31:0] RESET_FUNC_EN_2 = 32'h0011_0311;
  localparam logic [31:0] RESET_CLK_EN_1  = 32'h0000_0000;
  localparam logic [31:0] RESET_CLK_EN_2  = 32'h0000_0000;
  localparam int          NUM_PERIPH      = 16;
  // bit positions, first register
  localparam int BIT_FREE_RUN_TIMER = 26;
  localparam int BIT_TIMER_THREE    = 19;
  localparam int BIT_TIMER_ZERO     = 16;
  localparam int BIT_PORT_D         = 11;
  localparam int BIT_PORT_A         = 8;
  localparam int BIT_DIVIDER        = 5;
  // bit positions, second register
  localparam int BIT_ADC            = 20;
  localparam int BIT_MOTOR_PWM      = 16;
  localparam int BIT_SERIAL_ONE     = 9;
  localparam int BIT_SERIAL_ZERO    = 8;
  localparam int BIT_I2C            = 4;
  localparam int BIT_SPI            = 0;
endpackage

//--- periph_unit_model.sv
// model of one peripheral unit: counts gated clock pulses while released
// assumes active-high hold and a gated clock that idles low
`timescale 1ns/1ps
module periph_unit_model (
  input  wire logic        i_hold,  // held in reset
  input  wire logic        i_pclk,  // gated clock
  output logic      [15:0] o_ticks  // pulses seen since release
);
  initial o_ticks = 16'h0000;
  // counts only when clocked and released
  always @(posedge i_pclk or posedge i_hold) begin
    if (i_hold) begin
      o_ticks <= 16'h0000;
    end else begin
      o_ticks <= o_ticks + 16'h0001;
    end
  end
endmodule // periph_unit_model

//--- peripheral_enable_clock_gate_tb.sv
// testbench: register map, reset hold and clock gating over avalon-mm
// assumes hold index 15 is the free-run timer and 14 timer three
`timescale 1ns/1ps
module peripheral_enable_clock_gate_tb;
  logic        i_clk;
  logic        i_rst_b;
  logic [31:0] adr;
  logic        rd;
  logic        wr;
  logic [31:0] wd;
  logic [31:0] rdata;
  logic        wait_req;
  logic [15:0] hold;
  logic [15:0] pclk;
  logic [15:0] ticks;
  logic [15:0] ticks3;
  int          err_total;
  int          checked;
  int          cyc;
  logic [31:0] ad [4] = '{32'h4000_0028, 32'h4000_002C, 32'h4000_0030,
                          32'h4000_0034};
  logic [31:0] rv [4] = '{32'h040F_0F20, 32'h0011_0311, 32'h0000_0000,
                          32'h0000_0000};
  logic [31:0] mk [4] = '{32'h040F_0F20, 32'h0011_0311, 32'h040F_0F20,
                          32'h0011_0311};
  peripheral_enable_clock_gate peripheral_enable_clock_gate_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .o_periph_hold(hold),
    .o_periph_clk(pclk));
  periph_unit_model periph_unit_model_i (
    .i_hold(hold[15]), .i_pclk(pclk[15]), .o_ticks(ticks));
  periph_unit_model periph_unit_model_t3_i (
    .i_hold(hold[14]), .i_pclk(pclk[14]), .o_ticks(ticks3));
  //////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge i_clk); while (wait_req !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    // let the landed write settle before anyone looks at outputs
    @(negedge i_clk);
  endtask
  task automatic wrt(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input string nm, input logic [31:0] a,
                      input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk("hold_rst", 32'h0000_0000, {16'h0, hold});
    for (int i = 0; i < 4; i++) begin
      rchk("reg_rst", ad[i], rv[i]);
      wrt(ad[i], 32'hFFFF_FFFF);
      rchk("reg_ones", ad[i], mk[i]);
      wrt(ad[i], 32'h0000_0000);
      rchk("reg_zero", ad[i], 32'h0000_0000);
    end
    chk("hold_all", 32'h0000_FFFF, {16'h0, hold});
    wrt(32'h4000_0038, 32'hFFFF_FFFF);
    rchk("unmapped", 32'h4000_0038, 32'h0000_0000);
    wrt(ad[0], mk[0]);
    wrt(ad[1], mk[1]);
    chk("hold_rel", 32'h0000_0000, {16'h0, hold});
  endtask
  task automatic t_map;
    wrt(ad[0], 32'h0401_0100);
    wrt(ad[1], 32'h0000_0111);
    chk("hold_map_a", 32'h0000_7778, {16'h0, hold});
    wrt(ad[0], 32'h0008_0020);
    wrt(ad[1], 32'h0011_0200);
    chk("hold_map_b", 32'h0000_BF87, {16'h0, hold});
    wrt(ad[0], mk[0]);
    wrt(ad[1], mk[1]);
  endtask
  task automatic t_clock;
    logic [15:0] t0;
    wrt(ad[2], 32'h0400_0000);
    repeat (2) @(negedge i_clk);
    t0 = ticks;
    repeat (8) @(negedge i_clk);
    chk("ticks_on", {16'h0, t0 + 16'd8}, {16'h0, ticks});
    chk("general_timer_three_ticks", 32'h0000_0000, {16'h0, ticks3});
    wrt(ad[0], 32'h0000_0000);
    repeat (8) @(negedge i_clk);
    chk("ticks_held", 32'h0, {16'h0, ticks});
    wrt(ad[0], mk[0]);
    wrt(ad[2], 32'h0000_0000);
    repeat (2) @(negedge i_clk);
    t0 = ticks;
    repeat (8) @(negedge i_clk);
    chk("ticks_off", {16'h0, t0}, {16'h0, ticks});
  endtask
  task automatic t_reset;
    wrt(ad[0], 32'h0000_0000);
    wrt(ad[3], mk[3]);
    chk("hold_cut", 32'h0000_FFC0, {16'h0, hold});
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(negedge i_clk);
    chk("hold_rst2", 32'h0000_0000, {16'h0, hold});
    rchk("fe1_rst2", ad[0], rv[0]);
    rchk("ce2_rst2", ad[3], rv[3]);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    cyc = 0; err_total = 0; checked = 0;
    i_rst_b = 1'b0; adr = 32'h0; rd = 1'b0; wr = 1'b0; wd = 32'h0;
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_regs();
    t_map();
    t_clock();
    t_reset();
    close_out();
  end
endmodule // peripheral_enable_clock_gate_tb
